/* rtl/ee3w_eeprom.sv */
/*
  Three-wire serial EEPROM slave: pin front end, command decoder, a small
  program FIFO and the self-timed program engine, in one file.
  Assumes select, shift clock, data in and strap pins are asynchronous to clk_i,
  and that the bench resolves the data-out pin from serial_out_oe_o.
*/
`timescale 1ns/1ps

// ***************************************************************
// Program FIFO
// ***************************************************************
module ee3w_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = $clog2(D);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } ee3w_fifo_st_t;

  ee3w_fifo_st_t st_r, st_nxt;
  logic [W-1:0]  mem_r [D];
  logic          push, pop;

  // Honest flags straight from the count
  assign in_ready_o  = (st_r.cnt != (PW+1)'(D));
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o  = mem_r[st_r.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb begin
    st_nxt = st_r;
    if (push) st_nxt.wp = (st_r.wp == PW'(D-1)) ? '0 : st_r.wp + 1'b1;
    if (pop)  st_nxt.rp = (st_r.rp == PW'(D-1)) ? '0 : st_r.rp + 1'b1;
    st_nxt.cnt = st_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) st_r <= '0;
    else         st_r <= st_nxt;
  end

  // Storage carries no reset
  always_ff @(posedge clk_i) begin
    if (push) mem_r[st_r.wp] <= in_data_i;
  end
endmodule

// ***************************************************************
// Device top
// ***************************************************************
module ee3w_eeprom #(
  parameter int   ADDR16_W   = ee3w_pkg::ADDR16_W_SMALL,
  parameter bit   HAS_PULLUP = 1'b1,
  parameter int   WRITE_CYC  = ee3w_pkg::WRITE_CYC,
  parameter int   FIFO_DEPTH = ee3w_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Serial link pins
  input  wire logic select_i,
  input  wire logic shift_clock_i,
  input  wire logic serial_in_i,
  output logic      serial_out_o,
  output logic      serial_out_oe_o,
  // Organisation strap
  input  wire logic word_width_strap_i,
  input  wire logic word_width_strap_driven_i
);
  localparam int BW        = ADDR16_W + 1;
  localparam int MEM_BYTES = 2 ** BW;

  ee3w_pkg::ee3w_core_t st, nx;
  logic [7:0]           mem_r [MEM_BYTES];
  logic                 mem_we;
  logic [BW-1:0]        mem_wa;
  logic [7:0]           mem_wd;
  logic                 f_in_ready, f_out_valid, f_out_ready;
  logic [ee3w_pkg::OP_W-1:0] f_out_data;
  ee3w_pkg::ee3w_op_t   f_op;
  logic                 wide, sk_rise, cs_rise, cs_fall, busy;
  logic [4:0]           aw_last, dw_last;
  logic [10:0]          wr_count;

  // Top two address bits carry the special subcode
  function automatic logic [1:0] subcode(input logic [8:0] a, input logic w);
    return w ? a[ADDR16_W-1 -: 2] : a[ADDR16_W -: 2];
  endfunction

  // Byte index of a word address
  function automatic logic [BW-1:0] byte_of(input logic [8:0] a, input logic w, input logic hi);
    return w ? {a[ADDR16_W-1:0], hi} : a[BW-1:0];
  endfunction

  // Organisation; an undriven strap without pull-up falls back to x8
  assign wide    = st.s2.strap_driven ? st.s2.strap : HAS_PULLUP;
  assign aw_last = wide ? 5'(ADDR16_W - 1) : 5'(ADDR16_W);
  assign dw_last = wide ? 5'(ee3w_pkg::WORD16_W - 1) : 5'(ee3w_pkg::WORD8_W - 1);
  assign sk_rise = st.s2.select && st.s2.shift_clock && !st.sk_q;
  assign cs_rise = st.s2.select && !st.cs_q;
  assign cs_fall = !st.s2.select && st.cs_q;
  assign busy    = st.pend || f_out_valid || st.prog;
  assign f_op    = ee3w_pkg::ee3w_op_t'(f_out_data);
  assign f_out_ready = !st.prog;
  assign wr_count = st.op.all ? 11'(MEM_BYTES) : (st.op.wide ? 11'h002 : 11'h001);

  // Program byte write, one byte per cycle from timer start until wr_count bytes are written
  always_comb begin
    mem_we = st.prog && (11'(st.idx) < wr_count);
    mem_wa = st.op.all ? st.idx[BW-1:0] : byte_of(st.op.addr, st.op.wide, st.idx[0]);
    mem_wd = (st.op.wide && st.idx[0]) ? st.op.data[15:8] : st.op.data[7:0];
  end

  // Whole next-state: syncs, decoder, status, program engine
  always_comb begin
    nx      = st;
    nx.s1   = '{select_i, shift_clock_i, serial_in_i, word_width_strap_i,
                word_width_strap_driven_i};
    nx.s2   = st.s1;
    nx.sk_q = st.s2.shift_clock;
    nx.cs_q = st.s2.select;
    if (sk_rise) begin
      case (st.state)
        ee3w_pkg::ST_IDLE: begin
          if (st.s2.serial_in == ee3w_pkg::START_MARKER) begin
            nx.state     = ee3w_pkg::ST_OPC;
            nx.cnt       = '0;
            nx.stat_mode = 1'b0;
          end
        end
        ee3w_pkg::ST_OPC: begin
          nx.opc = {st.opc[0], st.s2.serial_in};
          nx.cnt = st.cnt + 5'h01;
          if (st.cnt == 5'h01) begin
            nx.state = ee3w_pkg::ST_ADDR;
            nx.cnt   = '0;
          end
        end
        ee3w_pkg::ST_ADDR: begin
          nx.addr = {st.addr[7:0], st.s2.serial_in};
          nx.cnt  = st.cnt + 5'h01;
          if (st.cnt == aw_last) begin
            nx.cnt = '0;
            if (st.opc == ee3w_pkg::OPC_READ) begin
              nx.state = ee3w_pkg::ST_READ;
              nx.shout = wide ? {mem_r[byte_of(nx.addr, 1'b1, 1'b1)],
                                 mem_r[byte_of(nx.addr, 1'b1, 1'b0)]}
                              : {mem_r[byte_of(nx.addr, 1'b0, 1'b0)], 8'h00};
            end else if (st.opc == ee3w_pkg::OPC_WRITE ||
                         (st.opc == ee3w_pkg::OPC_SPECIAL &&
                          subcode(nx.addr, wide) == ee3w_pkg::SUB_FILL_ALL)) begin
              nx.state = ee3w_pkg::ST_DATA;
            end else begin
              nx.state = ee3w_pkg::ST_IDLE;
              nx.hold  = 1'b1;
            end
          end
        end
        ee3w_pkg::ST_DATA: begin
          nx.data = {st.data[14:0], st.s2.serial_in};
          nx.cnt  = st.cnt + 5'h01;
          if (st.cnt == dw_last) begin
            nx.state = ee3w_pkg::ST_IDLE;
            nx.hold  = 1'b1;
          end
        end
        ee3w_pkg::ST_READ: begin
          nx.shout = {st.shout[14:0], 1'b0};
        end
        default: nx.state = ee3w_pkg::ST_IDLE;
      endcase
    end
    // Deselect executes a complete instruction, then drops any partial one
    if (cs_fall) begin
      nx.state = ee3w_pkg::ST_IDLE;
      nx.hold  = 1'b0;
      if (st.hold && st.opc == ee3w_pkg::OPC_SPECIAL &&
          subcode(st.addr, wide) == ee3w_pkg::SUB_UNLOCK) begin
        nx.unlocked = 1'b1;
      end else if (st.hold && st.opc == ee3w_pkg::OPC_SPECIAL &&
                   subcode(st.addr, wide) == ee3w_pkg::SUB_LOCK) begin
        nx.unlocked = 1'b0;
      end else if (st.hold && st.opc != ee3w_pkg::OPC_READ && st.unlocked && !st.pend) begin
        nx.pend      = 1'b1;
        nx.stat_arm  = 1'b1;
        nx.pop.wide  = wide;
        nx.pop.addr  = st.addr;
        nx.pop.all   = (st.opc == ee3w_pkg::OPC_SPECIAL);
        nx.pop.data  = (st.opc == ee3w_pkg::OPC_ERASE ||
                        (st.opc == ee3w_pkg::OPC_SPECIAL &&
                         subcode(st.addr, wide) == ee3w_pkg::SUB_ERASE_ALL))
                       ? ee3w_pkg::ERASED_WORD : st.data;
        if (!wide) nx.pop.data[15:8] = nx.pop.data[7:0];
      end
    end
    // Reselect after a queued write shows status
    if (cs_rise && st.stat_arm) begin
      nx.stat_mode = 1'b1;
      nx.stat_arm  = 1'b0;
    end
    // Hand the pending operation to the FIFO; a full FIFO stalls here
    if (st.pend && f_in_ready) nx.pend = 1'b0;
    // Program engine: timed, self-contained
    if (!st.prog && f_out_valid) begin
      nx.prog  = 1'b1;
      nx.op    = f_op;
      nx.timer = '0;
      nx.idx   = '0;
    end else if (st.prog) begin
      nx.timer = st.timer + 32'h1;
      if (mem_we) nx.idx = st.idx + 10'h001;
      if (st.timer == 32'(WRITE_CYC - 1)) nx.prog = 1'b0;
    end
    // Registered pin drive; a read bit stands until the next shift clock rise
    nx.oe  = st.s2.select && (st.state == ee3w_pkg::ST_READ ||
             nx.state == ee3w_pkg::ST_READ || st.stat_mode);
    nx.out = (nx.state != ee3w_pkg::ST_READ) ? !busy :
             (st.state != ee3w_pkg::ST_READ) ? ee3w_pkg::READ_DUMMY :
             sk_rise ? st.shout[15] : st.out;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st       <= '0;
      st.state <= ee3w_pkg::ST_IDLE;
    end else begin
      st <= nx;
    end
  end

  // Array: no erase step, the new byte lands directly
  always_ff @(posedge clk_i) begin
    if (mem_we) mem_r[mem_wa] <= mem_wd;
  end

  ee3w_fifo #(.W(ee3w_pkg::OP_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (st.pend),
    .in_ready_o  (f_in_ready),
    .in_data_i   (st.pop),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out_data)
  );

  assign serial_out_o    = st.out;
  assign serial_out_oe_o = st.oe;

  // ***************************************************************
  // Checks
  // ***************************************************************
  select_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !st.s2.select |=> !serial_out_oe_o) else $error("output driven while deselected");
  strap_high_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.s2.strap_driven && st.s2.strap) |-> dw_last == 5'h0F) else $error("x16 not chosen");
  strap_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.s2.strap_driven && !st.s2.strap) |-> aw_last == 5'(ADDR16_W)) else $error("x8 not chosen");
  strap_float_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !st.s2.strap_driven |-> wide == HAS_PULLUP) else $error("floating strap default wrong");
  array_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
    ($fell(st.prog) && st.op.all) |-> 11'(st.idx) == 11'(MEM_BYTES))
    else $error("whole array not covered");
  read_dummy_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.state == ee3w_pkg::ST_ADDR && nx.state == ee3w_pkg::ST_READ && st.s2.select)
    |=> serial_out_oe_o && serial_out_o == ee3w_pkg::READ_DUMMY) else $error("read lead bit");
  read_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.state == ee3w_pkg::ST_READ && st.s2.select && !sk_rise) |=> $stable(serial_out_o))
    else $error("read bit did not stand");
  timer_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st.prog |-> st.timer < 32'(WRITE_CYC)) else $error("write time exceeded");
  locked_guard_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(st.pend) |-> $past(st.unlocked)) else $error("write queued while locked");
  busy_status_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.stat_mode && st.s2.select && st.state == ee3w_pkg::ST_IDLE) |=>
    serial_out_o == !$past(busy)) else $error("status bit wrong");
  start_bit_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.state == ee3w_pkg::ST_IDLE && nx.state == ee3w_pkg::ST_OPC) |-> st.s2.serial_in)
    else $error("instruction without start bit");
  reset_lock_a: assert property (@(posedge clk_i)
    $fell(reset_i) |-> !st.unlocked) else $error("unlocked after reset");
  read_seen_c: cover property (@(posedge clk_i) disable iff (reset_i)
    st.state == ee3w_pkg::ST_READ ##1 st.state == ee3w_pkg::ST_READ);
  prog_done_c: cover property (@(posedge clk_i) disable iff (reset_i) $fell(st.prog));
  fifo_full_c: cover property (@(posedge clk_i) disable iff (reset_i) st.pend && !f_in_ready);
endmodule

/* pkg/ee3w_pkg.sv */
/*
  Shared constants and types for the three-wire serial EEPROM slave.
  Assumes a single 50 MHz system clock; all pins arrive asynchronously.
*/
package ee3w_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_MHZ       = 50;
  localparam int WRITE_TIME_MS = 10;
  // Longest time, so rounds down (exact here)
  localparam int WRITE_CYC     = WRITE_TIME_MS * 1000 * CLK_MHZ;

  // ***************************************************************
  // Geometry
  // ***************************************************************
  localparam int ADDR16_W_SMALL = 6;   // x16 address bits, smallest density
  localparam int FIFO_DEPTH     = 4;
  localparam int WORD16_W       = 16;
  localparam int WORD8_W        = 8;

  // ***************************************************************
  // Instruction encodings
  // ***************************************************************
  localparam logic       START_MARKER   = 1'b1;
  localparam logic       READ_DUMMY     = 1'b0;
  localparam logic [1:0] OPC_SPECIAL    = 2'h0;
  localparam logic [1:0] OPC_WRITE      = 2'h1;
  localparam logic [1:0] OPC_READ       = 2'h2;
  localparam logic [1:0] OPC_ERASE      = 2'h3;
  localparam logic [1:0] SUB_LOCK       = 2'h0;
  localparam logic [1:0] SUB_FILL_ALL   = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL  = 2'h2;
  localparam logic [1:0] SUB_UNLOCK     = 2'h3;
  localparam logic [15:0] ERASED_WORD   = 16'hFFFF;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_OPC  = 5'h02,
    ST_ADDR = 5'h04,
    ST_DATA = 5'h08,
    ST_READ = 5'h10
  } ee3w_state_t;

  typedef struct packed {
    logic select;
    logic shift_clock;
    logic serial_in;
    logic strap;
    logic strap_driven;
  } ee3w_pins_t;

  typedef struct packed {
    logic        all;    // Every location
    logic        wide;   // x16 organisation
    logic [8:0]  addr;
    logic [15:0] data;
  } ee3w_op_t;

  localparam int OP_W = $bits(ee3w_op_t);

  typedef struct packed {
    ee3w_pins_t  s1;
    ee3w_pins_t  s2;
    logic        sk_q;
    logic        cs_q;
    ee3w_state_t state;
    logic [4:0]  cnt;
    logic [1:0]  opc;
    logic [8:0]  addr;
    logic [15:0] data;
    logic [15:0] shout;
    logic        hold;
    logic        unlocked;
    logic        stat_arm;
    logic        stat_mode;
    logic        pend;
    ee3w_op_t    pop;
    logic        prog;
    ee3w_op_t    op;
    logic [31:0] timer;
    logic [9:0]  idx;
    logic        out;
    logic        oe;
  } ee3w_core_t;

endpackage

/* verif/ee3w_host.sv */
/*
  Host model for the three-wire EEPROM slave: drives select, shift clock
  and serial data in, and resolves the released data-out pin.
  Assumes the device clock is clk_i at 50 MHz; link period is 8 clocks.
*/
`timescale 1ns/1ps

module ee3w_host (
  // Clock
  input  wire logic clk_i,
  // Link pins toward the device
  output logic      select_o,
  output logic      shift_clock_o,
  output logic      serial_in_o,
  input  wire logic serial_out_i,
  input  wire logic serial_out_oe_i
);
  logic last_r  = 1'b0;
  logic noise_r = 1'b0;
  logic din_r   = 1'b0;
  logic so_w;

  // Released pin has no pull, so show the inverse of the last driven bit
  assign so_w        = serial_out_oe_i ? serial_out_i : ~last_r;
  // Data in toggles outside frames so stale bits never look valid
  assign serial_in_o = select_o ? din_r : noise_r;

  // ***************************************************************
  // Pin history
  // ***************************************************************
  always @(posedge clk_i) begin
    noise_r <= ~noise_r;
    if (serial_out_oe_i) begin
      last_r <= serial_out_i;
    end
  end

  initial begin
    select_o      = 1'b0;
    shift_clock_o = 1'b0;
  end

  // Changes land 1 ns after the device clock edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One frame, first bit first; dout holds the pin 8 clocks after each rise
  task automatic xfer(input logic [31:0] din, input int n, output logic [31:0] dout);
    logic [31:0] sh;
    sh   = din << (32 - n);
    dout = '0;
    step(1);
    select_o = 1'b1;
    din_r    = sh[31];
    step(4);
    for (int i = 0; i < n; i++) begin
      shift_clock_o = 1'b1;
      step(4);
      shift_clock_o = 1'b0;
      sh            = sh << 1;
      din_r         = sh[31];
      step(4);
      dout = {dout[30:0], so_w};
    end
  endtask

  // Deselect ends the frame; shift clock already rests low
  task automatic release_sel();
    select_o = 1'b0;
    step(6);
  endtask

  // Reselect and wait for ready, bounded so a stuck busy cannot hang
  task automatic poll(output int cyc, output logic first, output logic oe_s);
    step(1);
    select_o = 1'b1;
    step(6);
    first = so_w;
    oe_s  = serial_out_oe_i;
    cyc   = 0;
    while (so_w !== 1'b1 && cyc < 1000) begin
      step(1);
      cyc++;
    end
    release_sel();
  endtask
endmodule

/* verif/three_wire_serial_eeprom_tb.sv */
/*
  Self-checking bench for the three-wire EEPROM slave.
  Assumes the host model in ee3w_host.sv and a shortened write timer.
*/
`timescale 1ns/1ps

module three_wire_serial_eeprom_tb;
  localparam int WR_CYC = 200;
  localparam int LIMIT  = 30000;

  logic clk_i     = 1'b0;
  logic reset_i   = 1'b1;
  logic strap     = 1'b1;
  logic strap_drv = 1'b1;
  logic sel;
  logic sclk;
  logic sdin;
  logic sout;
  logic oe;
  int   fail_count = 0;
  int   tests_run  = 0;
  int   cycles     = 0;

  // ***************************************************************
  // Clock, instances and timeout
  // ***************************************************************
  always #10 clk_i = ~clk_i;

  ee3w_eeprom #(.WRITE_CYC(WR_CYC)) u_ee3w_eeprom (
    .clk_i                     (clk_i),
    .reset_i                   (reset_i),
    .select_i                  (sel),
    .shift_clock_i             (sclk),
    .serial_in_i               (sdin),
    .serial_out_o              (sout),
    .serial_out_oe_o           (oe),
    .word_width_strap_i        (strap),
    .word_width_strap_driven_i (strap_drv)
  );

  ee3w_host u_ee3w_host (
    .clk_i           (clk_i),
    .select_o        (sel),
    .shift_clock_o   (sclk),
    .serial_in_o     (sdin),
    .serial_out_i    (sout),
    .serial_out_oe_i (oe)
  );

  // A hung handshake counts as a mismatch
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("FAIL timeout after %0d cycles", cycles);
      wrap_up();
    end
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic set_strap(input logic v, input logic drv);
    @(posedge clk_i);
    #1;
    strap     = v;
    strap_drv = drv;
  endtask

  // x16 command with 6 address bits, data appended when wdata is set
  task automatic op16(input logic [1:0] opc, input logic [5:0] a, input logic [15:0] d,
                      input bit wdata);
    logic [31:0] q;
    if (wdata) begin
      u_ee3w_host.xfer({7'h00, 1'b1, opc, a, d}, 25, q);
    end else begin
      u_ee3w_host.xfer({23'h000000, 1'b1, opc, a}, 9, q);
    end
    u_ee3w_host.release_sel();
  endtask

  task automatic read16(input logic [5:0] a, input logic [15:0] exp, input string what);
    logic [31:0] q;
    u_ee3w_host.xfer({6'h00, 1'b1, ee3w_pkg::OPC_READ, a, 17'h00000}, 26, q);
    check("read16 dummy", {15'h0000, q[17]}, 16'h0000);
    check(what, q[16:1], exp);
    u_ee3w_host.release_sel();
    check("oe after deselect", {15'h0000, oe}, 16'h0000);
  endtask

  task automatic read8(input logic [6:0] a, input logic [7:0] exp, input string what);
    logic [31:0] q;
    u_ee3w_host.xfer({13'h0000, 1'b1, ee3w_pkg::OPC_READ, a, 9'h000}, 19, q);
    check("read8 dummy", {15'h0000, q[9]}, 16'h0000);
    check(what, {8'h00, q[8:1]}, {8'h00, exp});
    u_ee3w_host.release_sel();
  endtask

  task automatic wait_ready();
    int   cyc;
    logic first;
    logic oe_s;
    u_ee3w_host.poll(cyc, first, oe_s);
    check("status drive", {15'h0000, oe_s}, 16'h0001);
    check("busy at reselect", {15'h0000, first}, 16'h0000);
    check("write time", {15'h0000, cyc <= WR_CYC + 20}, 16'h0001);
  endtask

  // Rejected write: reselect must not arm a status drive
  task automatic expect_no_status(input string what);
    int   cyc;
    logic first;
    logic oe_s;
    u_ee3w_host.poll(cyc, first, oe_s);
    check(what, {15'h0000, oe_s}, 16'h0000);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_locked();
    op16(ee3w_pkg::OPC_WRITE, 6'h05, 16'h0BAD, 1'b1);
    expect_no_status("write after reset");
    $display("test locked done");
  endtask

  task automatic t_fill();
    op16(ee3w_pkg::OPC_SPECIAL, {ee3w_pkg::SUB_UNLOCK, 4'h0}, 16'h0000, 1'b0);
    op16(ee3w_pkg::OPC_SPECIAL, {ee3w_pkg::SUB_FILL_ALL, 4'h0}, 16'hA5C3, 1'b1);
    wait_ready();
    read16(6'h00, 16'hA5C3, "fill word 0");
    read16(6'h3F, 16'hA5C3, "fill last word");
    op16(ee3w_pkg::OPC_WRITE, 6'h3F, 16'h1234, 1'b1);
    wait_ready();
    read16(6'h3F, 16'h1234, "overwrite");
    $display("test fill and write done");
  endtask

  task automatic t_bytes();
    logic [31:0] q;
    set_strap(1'b0, 1'b1);
    read8(7'h7F, 8'h12, "high byte");
    read8(7'h7E, 8'h34, "low byte");
    u_ee3w_host.xfer({14'h0000, 1'b1, ee3w_pkg::OPC_WRITE, 7'h00, 8'h5A}, 18, q);
    u_ee3w_host.release_sel();
    wait_ready();
    set_strap(1'b1, 1'b1);
    read16(6'h00, 16'hA55A, "word from byte");
    set_strap(1'b0, 1'b0);
    read16(6'h00, 16'hA55A, "floating strap");
    set_strap(1'b1, 1'b1);
    $display("test organisation done");
  endtask

  task automatic t_erase();
    op16(ee3w_pkg::OPC_ERASE, 6'h3F, 16'h0000, 1'b0);
    wait_ready();
    read16(6'h3F, ee3w_pkg::ERASED_WORD, "erase one");
    op16(ee3w_pkg::OPC_SPECIAL, {ee3w_pkg::SUB_ERASE_ALL, 4'h0}, 16'h0000, 1'b0);
    wait_ready();
    read16(6'h05, ee3w_pkg::ERASED_WORD, "erase all");
    $display("test erase done");
  endtask

  task automatic t_relock();
    op16(ee3w_pkg::OPC_SPECIAL, {ee3w_pkg::SUB_LOCK, 4'h0}, 16'h0000, 1'b0);
    op16(ee3w_pkg::OPC_WRITE, 6'h05, 16'h0000, 1'b1);
    expect_no_status("write when locked");
    read16(6'h05, ee3w_pkg::ERASED_WORD, "locked word kept");
    $display("test relock done");
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    repeat (4) @(posedge clk_i);
    t_locked();
    t_fill();
    t_bytes();
    t_erase();
    t_relock();
    wrap_up();
  end
endmodule
